// ==== alu_pkg.sv ====
package alu_pkg;
    // ==========================================
    // Data path widths
    localparam int DATA_W = 8;
    localparam int REG_COUNT = 16;
    localparam int REG_SEL_W = 4;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'b0;
    localparam int MSB_POS = 7;
    localparam int LSB_POS = 0;

    // ==========================================
    // Operation codes
    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_LOAD = 5'h01,
        OP_AND = 5'h02,
        OP_TEST = 5'h03,
        OP_COMPARE = 5'h04,
        OP_SHIFT_LEFT_ZERO_FILL = 5'h05,
        OP_SHIFT_RIGHT_ZERO_FILL = 5'h06,
        OP_SHIFT_LEFT_ONE_FILL = 5'h07,
        OP_SHIFT_RIGHT_ONE_FILL = 5'h08,
        OP_SHIFT_RIGHT_SIGN_EXTEND = 5'h09,
        OP_SHIFT_LEFT_REPLICATE_LSB = 5'h0A,
        OP_SHIFT_LEFT_THROUGH_CARRY = 5'h0B,
        OP_SHIFT_RIGHT_THROUGH_CARRY = 5'h0C,
        OP_ROTATE_LEFT = 5'h0D,
        OP_ROTATE_RIGHT = 5'h0E,
        OP_INPUT = 5'h0F,
        OP_OUTPUT = 5'h10
    } alu_op_e;
endpackage

// ==== shift_unit.sv ====
module shift_unit (
    input wire alu_pkg::alu_op_e op,
    input wire logic [alu_pkg::DATA_W-1:0] operand,
    input wire logic carryIn,
    output logic [alu_pkg::DATA_W-1:0] result,
    output logic carryOut
);
    import alu_pkg::*;
    always_comb begin
        result = operand;
        carryOut = carryIn;
        case (op)
            OP_SHIFT_LEFT_ZERO_FILL: begin
                result = {operand[MSB_POS-1:0], 1'b0};
                carryOut = operand[MSB_POS];
            end
            OP_SHIFT_RIGHT_ZERO_FILL: begin
                result = {1'b0, operand[MSB_POS:1]};
                carryOut = operand[LSB_POS];
            end
            OP_SHIFT_LEFT_ONE_FILL: begin
                result = {operand[MSB_POS-1:0], 1'b1};
                carryOut = operand[MSB_POS];
            end
            OP_SHIFT_RIGHT_ONE_FILL: begin
                result = {1'b1, operand[MSB_POS:1]};
                carryOut = operand[LSB_POS];
            end
            OP_SHIFT_RIGHT_SIGN_EXTEND: begin
                result = {operand[MSB_POS], operand[MSB_POS:1]};
                carryOut = operand[LSB_POS];
            end
            OP_SHIFT_LEFT_REPLICATE_LSB: begin
                result = {operand[MSB_POS-1:0], operand[LSB_POS]};
                carryOut = operand[MSB_POS];
            end
            OP_SHIFT_LEFT_THROUGH_CARRY: begin
                result = {operand[MSB_POS-1:0], carryIn};
                carryOut = operand[MSB_POS];
            end
            OP_SHIFT_RIGHT_THROUGH_CARRY: begin
                result = {carryIn, operand[MSB_POS:1]};
                carryOut = operand[LSB_POS];
            end
            OP_ROTATE_LEFT: begin
                result = {operand[MSB_POS-1:0], operand[MSB_POS]};
                carryOut = operand[MSB_POS];
            end
            OP_ROTATE_RIGHT: begin
                result = {operand[LSB_POS], operand[MSB_POS:1]};
                carryOut = operand[LSB_POS];
            end
            default: begin
                result = operand;
                carryOut = carryIn;
            end
        endcase
    end
endmodule // shift_unit

// ==== logic_unit.sv ====
module logic_unit (
    input wire alu_pkg::alu_op_e op,
    input wire logic [alu_pkg::DATA_W-1:0] first,
    input wire logic [alu_pkg::DATA_W-1:0] second,
    output logic [alu_pkg::DATA_W-1:0] result,
    output logic carryOut,
    output logic zeroOut
);
    import alu_pkg::*;
    logic [DATA_W:0] diff;
    logic [DATA_W-1:0] masked;
    assign masked = first & second;
    assign diff = {1'b0, first} - {1'b0, second};
    always_comb begin
        result = masked;
        carryOut = 1'b0;
        zeroOut = (masked == '0);
        case (op)
            OP_AND: begin
                result = masked;
                carryOut = 1'b0;
                zeroOut = (masked == '0);
            end
            OP_TEST: begin
                result = masked;
                carryOut = ^masked;
                zeroOut = (masked == '0);
            end
            OP_COMPARE: begin
                result = diff[DATA_W-1:0];
                carryOut = diff[DATA_W];
                zeroOut = (diff[DATA_W-1:0] == '0);
            end
            default: begin
                result = masked;
                carryOut = 1'b0;
                zeroOut = (masked == '0);
            end
        endcase
    end
endmodule // logic_unit

// ==== alu_flag_shift_datapath.sv ====
// Functional notes
// - AND with itself keeps value, clears carry
// - Test and compare change only flags
// - Test ANDs operands; zero when all bits clear
// - Test carry is odd parity of masked bits
// - Compare subtracts, discards, zero when equal
// - Compare carry when first below second unsigned
// - Shifts act in place, update both flags
// - Left zero fill, bit seven to carry
// - Right zero fill, bit zero to carry
// - One fill shifts always clear zero
// - Sign right shift keeps bit seven
// - Replicate left shift copies old bit zero
// - Left through carry: carry in, bit7 out
// - Right through carry: carry in, bit0 out
// - Rotate left, bit seven to bit0, carry
// - Rotate right, bit zero to bit7, carry
// - Loads copy register or immediate, flags kept
// - Input writes sampled input byte to register
// - Output drives data from a register
// - IO address from register or immediate
module alu_flag_shift_datapath (
    input wire logic clk,
    input wire logic reset,
    input wire logic opValid,
    input wire alu_pkg::alu_op_e op,
    input wire logic [alu_pkg::REG_SEL_W-1:0] firstSel,
    input wire logic [alu_pkg::REG_SEL_W-1:0] secondSel,
    input wire logic useImmediate,
    input wire logic [alu_pkg::DATA_W-1:0] immediateConstant,
    input wire logic [alu_pkg::DATA_W-1:0] inPortData,
    output logic [alu_pkg::DATA_W-1:0] outPortData,
    output logic [alu_pkg::DATA_W-1:0] ioAddress,
    output logic writeStrobe,
    output logic readStrobe,
    output logic carryFlag,
    output logic zeroFlag,
    output logic [alu_pkg::DATA_W-1:0] regReadData
);
    import alu_pkg::*;

    // ==========================================
    // Register file and operand selection
    logic [DATA_W-1:0] regFile_reg [REG_COUNT];
    logic [DATA_W-1:0] firstVal;
    logic [DATA_W-1:0] secondVal;
    logic [DATA_W-1:0] shiftResult;
    logic shiftCarry;
    logic [DATA_W-1:0] logicResult;
    logic logicCarry;
    logic logicZero;
    logic isShift;
    logic isOneFill;
    logic writeReg;
    logic [DATA_W-1:0] writeData;
    logic carry_next;
    logic zero_next;

    assign firstVal = regFile_reg[firstSel];
    assign secondVal = useImmediate ? immediateConstant : regFile_reg[secondSel];

    shift_unit shifter (
        .op(op),
        .operand(firstVal),
        .carryIn(carryFlag),
        .result(shiftResult),
        .carryOut(shiftCarry)
    );

    logic_unit logicOps (
        .op(op),
        .first(firstVal),
        .second(secondVal),
        .result(logicResult),
        .carryOut(logicCarry),
        .zeroOut(logicZero)
    );

    always_comb begin
        isShift = 1'b0;
        isOneFill = 1'b0;
        case (op)
            OP_SHIFT_LEFT_ZERO_FILL, OP_SHIFT_RIGHT_ZERO_FILL,
            OP_SHIFT_RIGHT_SIGN_EXTEND, OP_SHIFT_LEFT_REPLICATE_LSB,
            OP_SHIFT_LEFT_THROUGH_CARRY, OP_SHIFT_RIGHT_THROUGH_CARRY,
            OP_ROTATE_LEFT, OP_ROTATE_RIGHT: begin
                isShift = 1'b1;
            end
            OP_SHIFT_LEFT_ONE_FILL, OP_SHIFT_RIGHT_ONE_FILL: begin
                isShift = 1'b1;
                isOneFill = 1'b1;
            end
            default: begin
                isShift = 1'b0;
                isOneFill = 1'b0;
            end
        endcase
    end

    // ==========================================
    // Write-back selection
    always_comb begin
        writeReg = 1'b0;
        writeData = firstVal;
        carry_next = carryFlag;
        zero_next = zeroFlag;
        if (opValid) begin
            if (isShift) begin
                writeReg = 1'b1;
                writeData = shiftResult;
                carry_next = shiftCarry;
                zero_next = isOneFill ? 1'b0 : (shiftResult == '0);
            end else begin
                case (op)
                    OP_LOAD: begin
                        writeReg = 1'b1;
                        writeData = secondVal;
                    end
                    OP_AND: begin
                        writeReg = 1'b1;
                        writeData = logicResult;
                        carry_next = logicCarry;
                        zero_next = logicZero;
                    end
                    OP_TEST, OP_COMPARE: begin
                        writeReg = 1'b0;
                        carry_next = logicCarry;
                        zero_next = logicZero;
                    end
                    OP_INPUT: begin
                        writeReg = 1'b1;
                        writeData = inPortData;
                    end
                    default: begin
                        writeReg = 1'b0;
                    end
                endcase
            end
        end
    end

    // ==========================================
    // Register file storage
    generate
        for (genvar i = 0; i < REG_COUNT; i++) begin : gRegs
            always_ff @(posedge clk or posedge reset) begin
                if (reset) begin
                    regFile_reg[i] <= REG_RESET;
                end else if (writeReg && firstSel == REG_SEL_W'(i)) begin
                    regFile_reg[i] <= writeData;
                end
            end
        end
    endgenerate

    // ==========================================
    // Flags
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            carryFlag <= FLAG_RESET;
            zeroFlag <= FLAG_RESET;
        end else begin
            carryFlag <= carry_next;
            zeroFlag <= zero_next;
        end
    end

    // ==========================================
    // Port data and address
    // Address and data are held after the operation so fabric can latch them late
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            outPortData <= REG_RESET;
            ioAddress <= REG_RESET;
            writeStrobe <= 1'b0;
            readStrobe <= 1'b0;
        end else begin
            writeStrobe <= opValid && op == OP_OUTPUT;
            readStrobe <= opValid && op == OP_INPUT;
            if (opValid && (op == OP_OUTPUT || op == OP_INPUT)) begin
                ioAddress <= secondVal;
            end
            if (opValid && op == OP_OUTPUT) begin
                outPortData <= firstVal;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            regReadData <= REG_RESET;
        end else begin
            regReadData <= writeReg ? writeData : firstVal;
        end
    end

    // ==========================================
    // Checks
    sequence seqTestIssued;
        opValid && op == OP_TEST;
    endsequence

    chk_test_parity_carry: assert property (@(posedge clk) disable iff (reset)
        seqTestIssued |=> carryFlag == ^($past(firstVal) & $past(secondVal)))
        else $error("test carry not odd parity");
    chk_test_zero_flag: assert property (@(posedge clk) disable iff (reset)
        seqTestIssued |=> zeroFlag == (($past(firstVal) & $past(secondVal)) == '0))
        else $error("test zero wrong");
    chk_flag_ops_nowrite: assert property (@(posedge clk) disable iff (reset)
        opValid && (op == OP_TEST || op == OP_COMPARE) |-> !writeReg)
        else $error("test or compare wrote register");
    chk_compare_carry_less: assert property (@(posedge clk) disable iff (reset)
        opValid && op == OP_COMPARE |=> carryFlag == ($past(firstVal) < $past(secondVal)))
        else $error("compare carry wrong");
    chk_compare_zero_equal: assert property (@(posedge clk) disable iff (reset)
        opValid && op == OP_COMPARE |=> zeroFlag == ($past(firstVal) == $past(secondVal)))
        else $error("compare zero wrong");
    chk_and_self_carry: assert property (@(posedge clk) disable iff (reset)
        opValid && op == OP_AND && firstSel == secondSel && !useImmediate
        |=> !carryFlag && regFile_reg[$past(firstSel)] == $past(firstVal))
        else $error("and self altered value or carry");
    chk_load_flags_kept: assert property (@(posedge clk) disable iff (reset)
        opValid && op == OP_LOAD |=> $stable(carryFlag) && $stable(zeroFlag))
        else $error("load changed flags");
    chk_one_fill_zero: assert property (@(posedge clk) disable iff (reset)
        opValid && isOneFill |=> !zeroFlag)
        else $error("one fill left zero set");
    chk_rotate_left_val: assert property (@(posedge clk) disable iff (reset)
        opValid && op == OP_ROTATE_LEFT |=> regFile_reg[$past(firstSel)]
        == {$past(firstVal[6:0]), $past(firstVal[7])} && carryFlag == $past(firstVal[7]))
        else $error("rotate left wrong");
    chk_output_data_addr: assert property (@(posedge clk) disable iff (reset)
        opValid && op == OP_OUTPUT |=> writeStrobe && outPortData == $past(firstVal)
        && ioAddress == $past(secondVal))
        else $error("output data or address wrong");
    chk_input_write: assert property (@(posedge clk) disable iff (reset)
        opValid && op == OP_INPUT |=> regFile_reg[$past(firstSel)] == $past(inPortData))
        else $error("input byte not written");

    // ==========================================
    // Shift and move checks
    // One sequence per issued code keeps each property down to its effect
    sequence seqOpIssued(alu_op_e code);
        opValid && op == code;
    endsequence

    chk_flag_ops_keep: assert property (@(posedge clk) disable iff (reset)
        opValid && (op == OP_TEST || op == OP_COMPARE)
        |=> regFile_reg[$past(firstSel)] == $past(firstVal))
        else $error("test or compare changed register");
    chk_shift_in_place: assert property (@(posedge clk) disable iff (reset)
        opValid && isShift && firstSel != secondSel
        |=> regFile_reg[$past(secondSel)] == $past(regFile_reg[secondSel]))
        else $error("shift touched another register");
    chk_left_zero_val: assert property (@(posedge clk) disable iff (reset)
        seqOpIssued(OP_SHIFT_LEFT_ZERO_FILL) |=> regFile_reg[$past(firstSel)]
        == {$past(firstVal[6:0]), 1'b0} && carryFlag == $past(firstVal[7]))
        else $error("left zero fill wrong");
    chk_right_zero_val: assert property (@(posedge clk) disable iff (reset)
        seqOpIssued(OP_SHIFT_RIGHT_ZERO_FILL) |=> regFile_reg[$past(firstSel)]
        == {1'b0, $past(firstVal[7:1])} && carryFlag == $past(firstVal[0]))
        else $error("right zero fill wrong");
    chk_left_one_val: assert property (@(posedge clk) disable iff (reset)
        seqOpIssued(OP_SHIFT_LEFT_ONE_FILL) |=> regFile_reg[$past(firstSel)]
        == {$past(firstVal[6:0]), 1'b1} && carryFlag == $past(firstVal[7]))
        else $error("left one fill wrong");
    chk_right_one_val: assert property (@(posedge clk) disable iff (reset)
        seqOpIssued(OP_SHIFT_RIGHT_ONE_FILL) |=> regFile_reg[$past(firstSel)]
        == {1'b1, $past(firstVal[7:1])} && carryFlag == $past(firstVal[0]))
        else $error("right one fill wrong");
    chk_sign_extend_val: assert property (@(posedge clk) disable iff (reset)
        seqOpIssued(OP_SHIFT_RIGHT_SIGN_EXTEND) |=> regFile_reg[$past(firstSel)]
        == {$past(firstVal[7]), $past(firstVal[7:1])} && carryFlag == $past(firstVal[0]))
        else $error("sign extend shift wrong");
    chk_replicate_val: assert property (@(posedge clk) disable iff (reset)
        seqOpIssued(OP_SHIFT_LEFT_REPLICATE_LSB) |=> regFile_reg[$past(firstSel)]
        == {$past(firstVal[6:0]), $past(firstVal[0])} && carryFlag == $past(firstVal[7]))
        else $error("replicate shift wrong");
    // Through-carry shifts must use the flag as it stood before the op
    chk_carry_left_val: assert property (@(posedge clk) disable iff (reset)
        seqOpIssued(OP_SHIFT_LEFT_THROUGH_CARRY) |=> regFile_reg[$past(firstSel)]
        == {$past(firstVal[6:0]), $past(carryFlag)} && carryFlag == $past(firstVal[7]))
        else $error("left through carry wrong");
    chk_carry_right_val: assert property (@(posedge clk) disable iff (reset)
        seqOpIssued(OP_SHIFT_RIGHT_THROUGH_CARRY) |=> regFile_reg[$past(firstSel)]
        == {$past(carryFlag), $past(firstVal[7:1])} && carryFlag == $past(firstVal[0]))
        else $error("right through carry wrong");
    chk_rotate_right_val: assert property (@(posedge clk) disable iff (reset)
        seqOpIssued(OP_ROTATE_RIGHT) |=> regFile_reg[$past(firstSel)]
        == {$past(firstVal[0]), $past(firstVal[7:1])} && carryFlag == $past(firstVal[0]))
        else $error("rotate right wrong");
    chk_shift_zero_result: assert property (@(posedge clk) disable iff (reset)
        opValid && isShift && !isOneFill
        |=> zeroFlag == (regFile_reg[$past(firstSel)] == '0))
        else $error("shift zero flag wrong");
    chk_load_value: assert property (@(posedge clk) disable iff (reset)
        seqOpIssued(OP_LOAD)
        |=> regFile_reg[$past(firstSel)] == $past(secondVal))
        else $error("load value wrong");
    chk_input_addr: assert property (@(posedge clk) disable iff (reset)
        seqOpIssued(OP_INPUT)
        |=> readStrobe && ioAddress == $past(secondVal))
        else $error("input address or strobe wrong");
endmodule // alu_flag_shift_datapath

// ==== port_fabric_model.sv ====
// ==========================================
// Fabric register on the I/O ports
module port_fabric_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic writeStrobe,
    input wire logic [alu_pkg::DATA_W-1:0] outPortData,
    output logic [alu_pkg::DATA_W-1:0] inPortData
);
    timeunit 1ns;
    timeprecision 100ps;
    import alu_pkg::*;
    logic [DATA_W-1:0] heldReg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            heldReg <= 8'h00;
        end else if (writeStrobe) begin
            heldReg <= outPortData;
        end
    end

    // Returns the inverse, so a bus that never changed cannot pass for a read
    assign inPortData = ~heldReg;
endmodule // port_fabric_model

// ==== tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import alu_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic opValid = 1'b0;
    alu_op_e op = OP_NONE;
    logic [3:0] firstSel = 4'h0;
    logic [3:0] secondSel = 4'h0;
    logic useImmediate = 1'b0;
    logic [7:0] immediateConstant = 8'h00;
    logic [7:0] inPortData, outPortData, ioAddress, regReadData;
    logic writeStrobe, readStrobe, carryFlag, zeroFlag;
    int errorCnt = 0;
    int numChecks = 0;

    alu_flag_shift_datapath alu_flag_shift_datapath_inst (.clk(clk), .reset(reset), .opValid(opValid), .op(op),
        .firstSel(firstSel), .secondSel(secondSel), .useImmediate(useImmediate),
        .immediateConstant(immediateConstant), .inPortData(inPortData), .outPortData(outPortData),
        .ioAddress(ioAddress), .writeStrobe(writeStrobe), .readStrobe(readStrobe), .carryFlag(carryFlag),
        .zeroFlag(zeroFlag), .regReadData(regReadData));
    port_fabric_model port_fabric_model_inst (.clk(clk), .reset(reset), .writeStrobe(writeStrobe),
        .outPortData(outPortData), .inPortData(inPortData));

    always #2 clk = ~clk;

    // ==========================================
    // Compare and bus tasks
    task automatic giveVerdict();
        $display("checks %0d mismatches %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic checkByte(input logic [7:0] got, input logic [7:0] exp, input string what);
        numChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic checkFlag(input logic got, input logic exp, input string what);
        numChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("unexpected at %0t: %s got %b want %b", $time, what, got, exp);
        end
    endtask

    task automatic issue(input alu_op_e o, input logic [3:0] f, input logic [3:0] s, input logic i,
                         input logic [7:0] k);
        @(posedge clk);
        opValid <= 1'b1;
        op <= o;
        firstSel <= f;
        secondSel <= s;
        useImmediate <= i;
        immediateConstant <= k;
        @(posedge clk);
        opValid <= 1'b0;
        #1;
    endtask

    // Needs one idle cycle: the read port shows the previous cycle's selection
    task automatic checkReg(input logic [3:0] r, input logic [7:0] exp);
        @(posedge clk);
        firstSel <= r;
        @(posedge clk);
        #1;
        checkByte(regReadData, exp, "register");
    endtask

    function automatic logic [8:0] shiftRef(alu_op_e o, logic [7:0] v, logic c);
        case (o)
            OP_SHIFT_LEFT_ZERO_FILL: return {v[7], v[6:0], 1'b0};
            OP_SHIFT_RIGHT_ZERO_FILL: return {v[0], 1'b0, v[7:1]};
            OP_SHIFT_LEFT_ONE_FILL: return {v[7], v[6:0], 1'b1};
            OP_SHIFT_RIGHT_ONE_FILL: return {v[0], 1'b1, v[7:1]};
            OP_SHIFT_RIGHT_SIGN_EXTEND: return {v[0], v[7], v[7:1]};
            OP_SHIFT_LEFT_REPLICATE_LSB: return {v[7], v[6:0], v[0]};
            OP_SHIFT_LEFT_THROUGH_CARRY: return {v[7], v[6:0], c};
            OP_SHIFT_RIGHT_THROUGH_CARRY: return {v[0], c, v[7:1]};
            OP_ROTATE_LEFT: return {v[7], v[6:0], v[7]};
            default: return {v[0], v[0], v[7:1]};
        endcase
    endfunction

    // ==========================================
    // Scenarios
    task automatic testReset();
        checkByte(outPortData, 8'h00, "out bus");
        checkByte(ioAddress, 8'h00, "address");
        checkFlag(carryFlag | zeroFlag | writeStrobe | readStrobe, 1'b0, "reset levels");
        checkReg(4'h9, REG_RESET);
        $display("test reset done");
    endtask

    task automatic testAndSelf();
        issue(OP_LOAD, 4'h0, 4'h0, 1'b1, 8'h00);
        issue(OP_LOAD, 4'h1, 4'h0, 1'b1, 8'hA5);
        issue(OP_COMPARE, 4'h0, 4'h0, 1'b1, 8'h01);
        checkFlag(carryFlag, 1'b1, "compare carry");
        checkFlag(zeroFlag, 1'b0, "compare zero");
        issue(OP_LOAD, 4'h2, 4'h1, 1'b0, 8'h00);
        checkFlag(carryFlag, 1'b1, "load keeps carry");
        checkReg(4'h2, 8'hA5);
        issue(OP_AND, 4'h1, 4'h1, 1'b0, 8'h00);
        checkFlag(carryFlag, 1'b0, "and carry");
        checkReg(4'h1, 8'hA5);
        $display("test and-self done");
    endtask

    task automatic testBitAndCompare();
        logic [7:0] va[4] = '{8'h05, 8'hA5, 8'hA5, 8'h07};
        logic [7:0] vb[4] = '{8'h04, 8'hFF, 8'h5A, 8'hFF};
        logic [7:0] r;
        for (int i = 0; i < 4; i++) begin
            issue(OP_LOAD, 4'h1, 4'h0, 1'b1, va[i]);
            issue(OP_LOAD, 4'h2, 4'h0, 1'b1, vb[i]);
            issue(OP_TEST, 4'h1, 4'h2, 1'(i), vb[i]);
            r = va[i] & vb[i];
            checkFlag(zeroFlag, r == 8'h00, "test zero");
            checkFlag(carryFlag, ^r, "test parity");
            checkReg(4'h1, va[i]);
            issue(OP_COMPARE, 4'h2, 4'h1, 1'b0, 8'h00);
            checkFlag(zeroFlag, va[i] == vb[i], "compare zero");
            checkFlag(carryFlag, vb[i] < va[i], "compare carry");
            checkReg(4'h2, vb[i]);
        end
        $display("test bit and compare done");
    endtask

    task automatic testShifts();
        logic [7:0] vals[4] = '{8'h81, 8'h00, 8'h01, 8'h80};
        logic [8:0] e;
        alu_op_e o;
        for (int k = 0; k < 10; k++) begin
            for (int i = 0; i < 8; i++) begin
                o = alu_op_e'(5'(k + 5));
                issue(OP_LOAD, 4'h5, 4'h0, 1'b1, vals[i / 2]);
                issue(i[0] ? OP_COMPARE : OP_AND, 4'h0, 4'h0, 1'b1, 8'h01);
                issue(o, 4'h5, 4'h0, 1'b0, 8'h00);
                e = shiftRef(o, vals[i / 2], i[0]);
                checkFlag(carryFlag, e[8], "shift carry");
                checkFlag(zeroFlag, (k == 2 || k == 3) ? 1'b0 : e[7:0] == 8'h00, "shift zero");
                checkReg(4'h5, e[7:0]);
            end
        end
        $display("test shifts done");
    endtask

    task automatic testPorts();
        issue(OP_LOAD, 4'h3, 4'h0, 1'b1, 8'h3C);
        issue(OP_LOAD, 4'h4, 4'h0, 1'b1, 8'h21);
        issue(OP_LOAD, 4'h7, 4'h0, 1'b1, 8'h22);
        issue(OP_OUTPUT, 4'h3, 4'h0, 1'b1, 8'h10);
        checkByte(outPortData, 8'h3C, "out bus");
        checkByte(ioAddress, 8'h10, "immediate address");
        checkFlag(writeStrobe, 1'b1, "write pulse");
        @(posedge clk);
        #1;
        checkFlag(writeStrobe, 1'b0, "write pulse end");
        issue(OP_OUTPUT, 4'h4, 4'h7, 1'b0, 8'h00);
        checkByte(outPortData, 8'h21, "out bus");
        checkByte(ioAddress, 8'h22, "register address");
        issue(OP_INPUT, 4'h6, 4'h0, 1'b1, 8'h11);
        checkFlag(readStrobe, 1'b1, "read pulse");
        checkByte(ioAddress, 8'h11, "input address");
        checkReg(4'h6, 8'hDE);
        $display("test ports done");
    endtask

    // Load then rotate on the next cycle: the rotate must see the fresh value
    task automatic testBackToBack();
        @(posedge clk);
        opValid <= 1'b1;
        op <= OP_LOAD;
        firstSel <= 4'h8;
        useImmediate <= 1'b1;
        immediateConstant <= 8'h81;
        @(posedge clk);
        op <= OP_ROTATE_LEFT;
        @(posedge clk);
        opValid <= 1'b0;
        #1;
        checkFlag(carryFlag, 1'b1, "rotate carry");
        checkReg(4'h8, 8'h03);
        $display("test back-to-back done");
    endtask

    initial begin
        repeat (8) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        testReset();
        testAndSelf();
        testBitAndCompare();
        testShifts();
        testPorts();
        testBackToBack();
        giveVerdict();
    end

    initial begin
        repeat (50000) @(posedge clk);
        errorCnt++;
        $display("unexpected at %0t: run did not finish", $time);
        giveVerdict();
    end
endmodule // tb_top
